/* rtl/sfs_pkg.sv */
// Purpose: Shared constants and carriers for the sync/FIFO/status bank
// Assumes: Byte-wide register port, one core clock
// Notes:   Offsets are byte addresses of the configuration serial port
package sfs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SFS_ADDR_SYNC_CONFIG  = 8'h50;
  localparam logic [7:0] SFS_ADDR_FIFO_CONFIG  = 8'h51;
  localparam logic [7:0] SFS_ADDR_MUTE_MASK    = 8'h54;
  localparam logic [7:0] SFS_ADDR_INT_MASK     = 8'h55;
  localparam logic [7:0] SFS_ADDR_STATUS       = 8'h56;
  localparam logic [7:0] SFS_ADDR_SERIAL_0     = 8'h57;
  localparam logic [7:0] SFS_ADDR_SERIAL_1     = 8'h58;
  localparam logic [7:0] SFS_ADDR_SERIAL_2     = 8'h59;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SFS_RST_SYNC_CONFIG   = 8'h00;
  localparam logic [7:0] SFS_RST_FIFO_CONFIG   = 8'h00;
  localparam logic [7:0] SFS_RST_MUTE_MASK     = 8'h00;
  localparam logic [7:0] SFS_RST_INT_MASK      = 8'h04;
  localparam logic [7:0] SFS_RST_STATUS        = 8'h00;
  // Arbitrary neutral serial number default
  localparam logic [23:0] SFS_SERIAL_DEFAULT   = 24'h00_0001;

  // ----------------------------------------------------------------
  // Field positions: sync config
  // ----------------------------------------------------------------
  localparam int SFS_SC_DIV_SYNC   = 6;
  localparam int SFS_SC_FIFO_SYNC  = 5;
  localparam int SFS_SC_OSC_SYNC   = 4;
  localparam int SFS_SC_OUT_SEL    = 2;
  localparam int SFS_SC_DLY_INC    = 1;
  localparam int SFS_SC_DLY_DEC    = 0;
  localparam logic [7:0] SFS_SC_RW_MASK = 8'h74;

  // Field positions: input FIFO config
  localparam int SFS_FC_RPA_LSB    = 4;
  localparam int SFS_FC_BYPASS     = 3;
  localparam int SFS_FC_DUP_I      = 2;
  localparam int SFS_FC_IQ_SWAP    = 1;
  localparam int SFS_FC_BIT_REV    = 0;

  // Field positions: status
  localparam int SFS_ST_PAR_I      = 7;
  localparam int SFS_ST_PAR_Q      = 6;
  localparam int SFS_ST_COLL       = 5;
  localparam int SFS_ST_ONE_APART  = 4;
  localparam int SFS_ST_TWO_APART  = 3;
  localparam int SFS_ST_TRIM_RDY   = 2;
  localparam int SFS_ST_PD_DONE    = 0;

  // Delay offset limit in DAC clock cycles
  localparam logic signed [4:0] SFS_DLY_MAX = 5'sd8;
  localparam logic signed [4:0] SFS_DLY_MIN = -5'sd8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       div_reset;
    logic       fifo_reset;
    logic       osc_reset;
  } sfs_sync_rst_s;

  typedef struct packed {
    logic [3:0] read_pointer_adjust;
    logic       bypass;
    logic       dup_i;
    logic       iq_swap;
    logic       bit_order_reverse;
  } sfs_fifo_cfg_s;

endpackage : sfs_pkg

/* rtl/sfs_regs.sv */
// Purpose: Sync, input FIFO config, masks, status and serial registers
// Assumes: Serial port decoded to byte write/read strobes on i_core_clk
// Notes:   Pins from outside the core domain pass a two-flop stage
//
// Contract
// R1: Divider sync enable gates sync input reset
// R2: FIFO sync enable gates sync input reset
// R3: Oscillator sync enable gates sync input reset
// R4: Output select: zero-phase or sync passthrough
// R5: Rising write of increase adds one cycle
// R6: Rising write of decrease removes one cycle
// R7: Delay offset clamped to plus/minus eight
// R8: Read address is pointer plus adjust
// R9: Bypass bit routes data around FIFO
// R10: Duplicate I bit duplicates in-phase data
// R11: Swap bit reverses I/Q order
// R12: Reverse bit flips data word bit order
// R13: Mute mask enables mute per status bit
// R14: Interrupt mask per bit, reset 0x04
// R15: Parity errors set status bits 7, 6
// R16: Pointer collision sets collision bit
// R17: One/two apart set bits 4, 3
// R18: Trim ready set after trim load
// R19: Peak done cleared by writing zero
// R20: Read-only 24-bit serial over three bytes
// R21: Peak done set at maximum count
// R22: Interrupt while masked status bit set
module sfs_regs
  import sfs_pkg::*;
#(
  parameter int          PTR_W  = 4,
  parameter int          DATA_W = 16,
  parameter logic [23:0] SERIAL = SFS_SERIAL_DEFAULT
)(
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_wr_en,
  input  wire logic              i_rd_en,
  input  wire logic [7:0]        i_addr,
  input  wire logic [7:0]        i_wdata,
  output logic      [7:0]        o_rdata,
  input  wire logic              i_sync_input,
  input  wire logic              i_zero_phase,
  input  wire logic              i_par_err_i,
  input  wire logic              i_par_err_q,
  input  wire logic              i_trim_done,
  input  wire logic              i_pd_max_reached,
  input  wire logic [PTR_W-1:0]  i_fifo_rd_ptr,
  input  wire logic [PTR_W-1:0]  i_fifo_wr_ptr,
  input  wire logic [DATA_W-1:0] i_data_i,
  input  wire logic [DATA_W-1:0] i_data_q,
  output logic                   o_sync_output,
  output sfs_sync_rst_s          o_sync_rst,
  output sfs_fifo_cfg_s          o_fifo_cfg,
  output logic      [PTR_W-1:0]  o_fifo_rd_addr,
  output logic      [DATA_W-1:0] o_data_first,
  output logic      [DATA_W-1:0] o_data_second,
  output logic signed [4:0]      o_delay_offset,
  output logic                   o_mute,
  output logic                   o_irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers (first stage read only by the second)
  // ----------------------------------------------------------------
  logic [1:0] sync_in_pipe_r;
  logic [1:0] zero_ph_pipe_r;
  logic       sync_in_s;
  logic       zero_ph_s;

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync_in_pipe_r <= 2'h0;
      zero_ph_pipe_r <= 2'h0;
    end
    else
    begin
      sync_in_pipe_r <= {sync_in_pipe_r[0], i_sync_input};
      zero_ph_pipe_r <= {zero_ph_pipe_r[0], i_zero_phase};
    end
  end

  assign sync_in_s = sync_in_pipe_r[1];
  assign zero_ph_s = zero_ph_pipe_r[1];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_sync;
  logic wr_fifo;
  logic wr_mute;
  logic wr_int;
  logic wr_stat;

  assign wr_sync = i_wr_en && (i_addr == SFS_ADDR_SYNC_CONFIG);
  assign wr_fifo = i_wr_en && (i_addr == SFS_ADDR_FIFO_CONFIG);
  assign wr_mute = i_wr_en && (i_addr == SFS_ADDR_MUTE_MASK);
  assign wr_int  = i_wr_en && (i_addr == SFS_ADDR_INT_MASK);
  assign wr_stat = i_wr_en && (i_addr == SFS_ADDR_STATUS);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] sync_cfg_r;
  logic [7:0] fifo_cfg_r;
  logic [7:0] mute_mask_r;
  logic [7:0] int_mask_r;
  logic [7:0] status_r;
  logic [7:0] status_nxt;

  // Strobe bits never stored: they read back zero, so self-clear
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync_cfg_r  <= SFS_RST_SYNC_CONFIG;
      fifo_cfg_r  <= SFS_RST_FIFO_CONFIG;
      mute_mask_r <= SFS_RST_MUTE_MASK;
      int_mask_r  <= SFS_RST_INT_MASK; // R14
    end
    else
    begin
      if (wr_sync)
        sync_cfg_r <= i_wdata & SFS_SC_RW_MASK;
      if (wr_fifo)
        fifo_cfg_r <= i_wdata;
      if (wr_mute)
        mute_mask_r <= i_wdata;
      if (wr_int)
        int_mask_r <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Output delay nudge, clamped
  // ----------------------------------------------------------------
  logic inc_req;
  logic dec_req;
  logic signed [4:0] dly_r;
  logic signed [4:0] dly_nxt;

  // Writing 1 counts as the 0-to-1 toggle since the bit reads as 0
  assign inc_req = wr_sync && i_wdata[SFS_SC_DLY_INC]; // R5
  assign dec_req = wr_sync && i_wdata[SFS_SC_DLY_DEC]; // R6
  // Both at once cancel; limits hold the offset inside the window
  assign dly_nxt = (inc_req && !dec_req && dly_r < SFS_DLY_MAX)
                   ? dly_r + 5'sd1
                   : (dec_req && !inc_req && dly_r > SFS_DLY_MIN)
                   ? dly_r - 5'sd1
                   : dly_r; // R7

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      dly_r <= 5'sd0;
    else
      dly_r <= dly_nxt;
  end

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic [PTR_W-1:0] ptr_gap;
  logic [7:0]       hw_set;
  logic [7:0]       live;

  assign ptr_gap = i_fifo_wr_ptr - i_fifo_rd_ptr;
  // Pointer and trim bits follow the live condition
  assign live[SFS_ST_COLL]      = (ptr_gap == PTR_W'(0)); // R16
  assign live[SFS_ST_ONE_APART] = (ptr_gap == PTR_W'(1)) ||
                                  (ptr_gap == PTR_W'(-1)); // R17
  assign live[SFS_ST_TWO_APART] = (ptr_gap == PTR_W'(2)) ||
                                  (ptr_gap == PTR_W'(-2)); // R17
  assign live[SFS_ST_TRIM_RDY]  = i_trim_done; // R18
  assign live[7:6] = 2'h0;
  assign live[1:0] = 2'h0;

  assign hw_set = {i_par_err_i, i_par_err_q, 5'h00,
                   i_pd_max_reached}; // R15 R21

  // Parity and peak bits are sticky; a set beats a same-cycle clear
  always_comb
  begin
    status_nxt = status_r;
    if (wr_stat && !i_wdata[SFS_ST_PD_DONE])
      status_nxt[SFS_ST_PD_DONE] = 1'b0; // R19
    if (wr_stat && !i_wdata[SFS_ST_PAR_I])
      status_nxt[SFS_ST_PAR_I] = 1'b0;
    if (wr_stat && !i_wdata[SFS_ST_PAR_Q])
      status_nxt[SFS_ST_PAR_Q] = 1'b0;
    status_nxt = status_nxt | hw_set;
    status_nxt[5:2] = live[5:2];
    status_nxt[1] = 1'b0;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      status_r <= SFS_RST_STATUS;
    else
      status_r <= status_nxt;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  assign rd_mux =
    (i_addr == SFS_ADDR_SYNC_CONFIG) ? sync_cfg_r  :
    (i_addr == SFS_ADDR_FIFO_CONFIG) ? fifo_cfg_r  :
    (i_addr == SFS_ADDR_MUTE_MASK)   ? mute_mask_r :
    (i_addr == SFS_ADDR_INT_MASK)    ? int_mask_r  :
    (i_addr == SFS_ADDR_STATUS)      ? status_r    :
    (i_addr == SFS_ADDR_SERIAL_0)    ? SERIAL[7:0]   : // R20
    (i_addr == SFS_ADDR_SERIAL_1)    ? SERIAL[15:8]  : // R20
    (i_addr == SFS_ADDR_SERIAL_2)    ? SERIAL[23:16] : // R20
    8'h00;

  // ----------------------------------------------------------------
  // Datapath steering from the FIFO config
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rev_i;
  logic [DATA_W-1:0] rev_q;
  logic [DATA_W-1:0] sel_q;

  // Bit reversal per bit, one generate loop
  for (genvar b = 0; b < DATA_W; b++)
  begin : g_rev
    assign rev_i[b] = fifo_cfg_r[SFS_FC_BIT_REV] ?
                      i_data_i[DATA_W-1-b] : i_data_i[b]; // R12
    assign rev_q[b] = fifo_cfg_r[SFS_FC_BIT_REV] ?
                      i_data_q[DATA_W-1-b] : i_data_q[b]; // R12
  end

  assign sel_q = fifo_cfg_r[SFS_FC_DUP_I] ? rev_i : rev_q; // R10

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Sync resets are the synchronised pulse gated by their enables
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rdata        <= 8'h00;
      o_sync_output  <= 1'b0;
      o_sync_rst     <= '0;
      o_fifo_cfg     <= '0;
      o_fifo_rd_addr <= '0;
      o_data_first   <= '0;
      o_data_second  <= '0;
      o_delay_offset <= 5'sd0;
      o_mute         <= 1'b0;
      o_irq          <= 1'b0;
    end
    else
    begin
      if (i_rd_en)
        o_rdata <= rd_mux;
      o_sync_output <= sync_cfg_r[SFS_SC_OUT_SEL] ?
                       zero_ph_s : sync_in_s; // R4
      o_sync_rst.div_reset  <= sync_in_s &&
                               sync_cfg_r[SFS_SC_DIV_SYNC]; // R1
      o_sync_rst.fifo_reset <= sync_in_s &&
                               sync_cfg_r[SFS_SC_FIFO_SYNC]; // R2
      o_sync_rst.osc_reset  <= sync_in_s &&
                               sync_cfg_r[SFS_SC_OSC_SYNC]; // R3
      o_fifo_cfg <= fifo_cfg_r; // R9 R11
      o_fifo_rd_addr <= i_fifo_rd_ptr +
        PTR_W'(fifo_cfg_r[SFS_FC_RPA_LSB +: 4]); // R8
      // Swap exchanges slot order after duplication
      o_data_first  <= fifo_cfg_r[SFS_FC_IQ_SWAP] ? sel_q : rev_i; // R11
      o_data_second <= fifo_cfg_r[SFS_FC_IQ_SWAP] ? rev_i : sel_q; // R11
      o_delay_offset <= dly_r;
      o_mute <= |(status_r & mute_mask_r); // R13
      o_irq  <= |(status_r & int_mask_r); // R14 R22
    end
  end

endmodule : sfs_regs

/* dv/sfs_regs_monitor.sv */
// Purpose: Port-level checks on the sync/FIFO/status bank
// Assumes: Latencies as given in the bank's hand-over
// Notes:   Interrupt mask copy and mute-mask zero flag are rebuilt from port writes
module sfs_regs_monitor
  import sfs_pkg::*;
#(
  parameter int          PTR_W  = 4,
  parameter logic [23:0] SERIAL = SFS_SERIAL_DEFAULT
)(
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  input wire logic              i_wr_en,
  input wire logic              i_rd_en,
  input wire logic [7:0]        i_addr,
  input wire logic [7:0]        i_wdata,
  input wire logic [7:0]        o_rdata,
  input wire logic              i_sync_input,
  input wire logic              i_zero_phase,
  input wire logic              i_par_err_i,
  input wire logic [PTR_W-1:0]  i_fifo_rd_ptr,
  input wire logic              o_sync_output,
  input wire sfs_sync_rst_s     o_sync_rst,
  input wire sfs_fifo_cfg_s     o_fifo_cfg,
  input wire logic [PTR_W-1:0]  o_fifo_rd_addr,
  input wire logic signed [4:0] o_delay_offset,
  input wire logic              o_mute,
  input wire logic              o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Shadow state and properties
  // ------
  default clocking mon_cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  logic [7:0] imask_r;
  logic       mzero_r;

  // Shadows move on the same edge as the bank's own mask registers
  always_ff @(posedge i_core_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      imask_r <= SFS_RST_INT_MASK;
      mzero_r <= 1'b1;
    end
    else if (i_wr_en && i_addr == SFS_ADDR_INT_MASK)
      imask_r <= i_wdata;
    else if (i_wr_en && i_addr == SFS_ADDR_MUTE_MASK)
      mzero_r <= (i_wdata == 8'h00);

  dly_clamp_a: assert property (
    o_delay_offset <= SFS_DLY_MAX && o_delay_offset >= SFS_DLY_MIN)
    else $error("delay offset out of range");
  dly_step_a: assert property (
    !$stable(o_delay_offset) |-> $past(i_wr_en, 2) &&
    $past(i_addr, 2) == SFS_ADDR_SYNC_CONFIG)
    else $error("delay moved without a sync config write");
  rd_addr_a: assert property (
    $past(i_rstn) && $stable(o_fifo_cfg) |-> o_fifo_rd_addr ==
    PTR_W'($past(i_fifo_rd_ptr) + $past(o_fifo_cfg.read_pointer_adjust)))
    else $error("read address is not pointer plus adjust");
  sync_rst_a: assert property (
    o_sync_rst != 3'b000 |-> $past(i_sync_input, 3))
    else $error("block reset without sync input");
  sync_out_a: assert property (
    o_sync_output |-> $past(i_sync_input, 3) || $past(i_zero_phase, 3))
    else $error("sync output high without a source");
  mute_off_a: assert property (
    $past(mzero_r) |-> !o_mute)
    else $error("mute with empty mute mask");
  irq_off_a: assert property (
    $past(imask_r) == 8'h00 |-> !o_irq)
    else $error("interrupt with empty interrupt mask");
  par_irq_a: assert property (
    $past(i_par_err_i, 2) && $past(imask_r[SFS_ST_PAR_I]) |-> o_irq)
    else $error("parity error did not raise interrupt");
  serial_hi_a: assert property (
    $past(i_rd_en) && $past(i_addr) == SFS_ADDR_SERIAL_2 |->
    o_rdata == SERIAL[23:16])
    else $error("serial top byte wrong");
endmodule : sfs_regs_monitor

bind sfs_regs sfs_regs_monitor #(.PTR_W(PTR_W), .SERIAL(SERIAL))
  sfs_regs_monitor_i (
    .i_core_clk     (i_core_clk),
    .i_rstn         (i_rstn),
    .i_wr_en        (i_wr_en),
    .i_rd_en        (i_rd_en),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .o_rdata        (o_rdata),
    .i_sync_input   (i_sync_input),
    .i_zero_phase   (i_zero_phase),
    .i_par_err_i    (i_par_err_i),
    .i_fifo_rd_ptr  (i_fifo_rd_ptr),
    .o_sync_output  (o_sync_output),
    .o_sync_rst     (o_sync_rst),
    .o_fifo_cfg     (o_fifo_cfg),
    .o_fifo_rd_addr (o_fifo_rd_addr),
    .o_delay_offset (o_delay_offset),
    .o_mute         (o_mute),
    .o_irq          (o_irq)
  );

/* dv/sfs_host.sv */
// Purpose: Host model of the byte register port
// Assumes: Bank takes a strobe on the rising edge
// Notes:   Drives on the falling edge, one idle cycle after a write, two after a read
module sfs_host (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // Released lines show inverted values so stale data never matches
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_core_clk);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : wr
  // Read data lands at the strobe edge and holds; taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_core_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    @(negedge i_core_clk);
    d = i_rdata;
  endtask : rd
endmodule : sfs_host

/* dv/sfs_regs_test.sv */
// Purpose: Directed register-level test of the sync/FIFO/status bank
// Assumes: Host model on the byte port, inputs moved on falling edges
// Notes:   Serial number set to an arbitrary test value
module sfs_regs_test
  import sfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] SER = 24'hA5_3C96;
  logic              i_core_clk, i_rstn, i_wr_en, i_rd_en;
  logic [7:0]        i_addr, i_wdata, o_rdata, rv;
  logic              i_sync_input, i_zero_phase, i_par_err_i, i_par_err_q;
  logic              i_trim_done, i_pd_max_reached, o_sync_output;
  logic              o_mute, o_irq;
  logic [3:0]        i_fifo_rd_ptr, i_fifo_wr_ptr, o_fifo_rd_addr;
  logic [15:0]       i_data_i, i_data_q, o_data_first, o_data_second;
  logic signed [4:0] o_delay_offset;
  sfs_sync_rst_s     o_sync_rst;
  sfs_fifo_cfg_s     o_fifo_cfg;
  int                miscompares, samples_checked;
  // Expectation tables
  logic [7:0]  ra [9] = '{8'h50, 8'h51, 8'h54, 8'h55, 8'h56,
                          8'h57, 8'h58, 8'h59, 8'h52};
  logic [7:0]  re [9] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00,
                          8'h96, 8'h3C, 8'hA5, 8'h00};
  logic [3:0]  gp [6] = '{4'h0, 4'h1, 4'h2, 4'hF, 4'hE, 4'h6};
  logic [7:0]  ge [6] = '{8'h20, 8'h10, 8'h08, 8'h10, 8'h08, 8'h00};
  logic [7:0]  fc [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'hF0};
  logic [15:0] f1 [5] = '{16'hC000, 16'h00C0, 16'h0003, 16'h0003, 16'h0003};
  logic [15:0] f2 [5] = '{16'h0300, 16'h0003, 16'h0003, 16'h00C0, 16'h00C0};
  logic [7:0]  sc [6] = '{8'h70, 8'h40, 8'h20, 8'h10, 8'h00, 8'h04};
  logic [3:0]  sv [6] = '{4'hF, 4'h9, 4'h5, 4'h3, 4'h1, 4'h0};

  sfs_regs #(.SERIAL(SER)) sfs_regs_i (
    .i_core_clk       (i_core_clk),
    .i_rstn           (i_rstn),
    .i_wr_en          (i_wr_en),
    .i_rd_en          (i_rd_en),
    .i_addr           (i_addr),
    .i_wdata          (i_wdata),
    .o_rdata          (o_rdata),
    .i_sync_input     (i_sync_input),
    .i_zero_phase     (i_zero_phase),
    .i_par_err_i      (i_par_err_i),
    .i_par_err_q      (i_par_err_q),
    .i_trim_done      (i_trim_done),
    .i_pd_max_reached (i_pd_max_reached),
    .i_fifo_rd_ptr    (i_fifo_rd_ptr),
    .i_fifo_wr_ptr    (i_fifo_wr_ptr),
    .i_data_i         (i_data_i),
    .i_data_q         (i_data_q),
    .o_sync_output    (o_sync_output),
    .o_sync_rst       (o_sync_rst),
    .o_fifo_cfg       (o_fifo_cfg),
    .o_fifo_rd_addr   (o_fifo_rd_addr),
    .o_data_first     (o_data_first),
    .o_data_second    (o_data_second),
    .o_delay_offset   (o_delay_offset),
    .o_mute           (o_mute),
    .o_irq            (o_irq)
  );
  sfs_host sfs_host_i (.i_core_clk(i_core_clk), .i_rdata(o_rdata),
    .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
    .o_wdata(i_wdata));

  // 250 MHz core clock
  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  // ------
  // Helpers
  // ------
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask : cyc
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    sfs_host_i.rd(a, rv);
    chk("rdata", {8'h00, e}, {8'h00, rv});
  endtask : rc
  // One-cycle event pulse, then time for status and outputs to settle
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask : pulse
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    miscompares++;
    conclude();
  end
  // Main sequence
  initial
  begin
    {i_rstn, i_sync_input, i_zero_phase, i_par_err_i} = 4'h0;
    {i_par_err_q, i_trim_done, i_pd_max_reached} = 3'h0;
    i_fifo_rd_ptr = 4'h3;
    i_fifo_wr_ptr = 4'h9;
    i_data_i = 16'h0003;
    i_data_q = 16'h00C0;
    miscompares = 0;
    samples_checked = 0;
    cyc(3);
    i_rstn = 1'b1;
    foreach (ra[k]) rc(ra[k], re[k]);
    sfs_host_i.wr(8'h52, 8'hFF);
    rc(8'h52, 8'h00);
    i_trim_done = 1'b1;
    cyc(3);
    chk("irq", 16'h0001, {15'h0, o_irq});
    rc(SFS_ADDR_STATUS, 8'h04);
    sfs_host_i.wr(SFS_ADDR_INT_MASK, 8'h00);
    cyc(2);
    chk("irq", 16'h0000, {15'h0, o_irq});
    i_trim_done = 1'b0;
    sfs_host_i.wr(SFS_ADDR_INT_MASK, 8'hC1);
    sfs_host_i.wr(SFS_ADDR_MUTE_MASK, 8'h80);
    rc(SFS_ADDR_INT_MASK, 8'hC1);
    rc(SFS_ADDR_MUTE_MASK, 8'h80);
    pulse(i_par_err_q);
    chk("mute", 16'h0000, {15'h0, o_mute});
    chk("irq", 16'h0001, {15'h0, o_irq});
    pulse(i_par_err_i);
    chk("mute", 16'h0001, {15'h0, o_mute});
    rc(SFS_ADDR_STATUS, 8'hC0);
    sfs_host_i.wr(SFS_ADDR_STATUS, 8'h00);
    rc(SFS_ADDR_STATUS, 8'h00);
    foreach (gp[k])
    begin
      i_fifo_wr_ptr = 4'h3 + gp[k];
      cyc(2);
      rc(SFS_ADDR_STATUS, ge[k]);
    end
    foreach (fc[k])
    begin
      sfs_host_i.wr(SFS_ADDR_FIFO_CONFIG, fc[k]);
      cyc(3);
      chk("fifo_cfg", {8'h00, fc[k]}, {8'h00, o_fifo_cfg});
      chk("first", f1[k], o_data_first);
      chk("second", f2[k], o_data_second);
    end
    chk("rd_addr", 16'h0002, {12'h000, o_fifo_rd_addr});
    repeat (10) sfs_host_i.wr(SFS_ADDR_SYNC_CONFIG, 8'h02);
    cyc(2);
    chk("delay", 16'h0008, {11'h000, o_delay_offset});
    rc(SFS_ADDR_SYNC_CONFIG, 8'h00);
    repeat (17) sfs_host_i.wr(SFS_ADDR_SYNC_CONFIG, 8'h01);
    cyc(2);
    chk("delay", 16'h0018, {11'h000, o_delay_offset});
    // Mid-run reset must restore the offset and the mask defaults
    i_rstn = 1'b0;
    cyc(2);
    i_rstn = 1'b1;
    cyc(2);
    chk("delay", 16'h0000, {11'h000, o_delay_offset});
    rc(SFS_ADDR_INT_MASK, 8'h04);
    rc(SFS_ADDR_MUTE_MASK, 8'h00);
    i_sync_input = 1'b1;
    foreach (sc[k])
    begin
      sfs_host_i.wr(SFS_ADDR_SYNC_CONFIG, sc[k]);
      cyc(4);
      chk("sync", {12'h000, sv[k]},
          {12'h000, o_sync_rst, o_sync_output});
    end
    i_sync_input = 1'b0;
    i_zero_phase = 1'b1;
    cyc(4);
    chk("sync_out", 16'h0001, {15'h0, o_sync_output});
    pulse(i_pd_max_reached);
    rc(SFS_ADDR_STATUS, 8'h01);
    sfs_host_i.wr(SFS_ADDR_STATUS, 8'hFF);
    rc(SFS_ADDR_STATUS, 8'h01);
    sfs_host_i.wr(SFS_ADDR_STATUS, 8'h00);
    rc(SFS_ADDR_STATUS, 8'h00);
    conclude();
  end
endmodule : sfs_regs_test
